// File: crcrf_cfg.svh
// Offsets, reset values, field positions and the gain reserved-bit mask for the CRC/RF configuration registers
`ifndef CRCRF_CFG_SVH
`define CRCRF_CFG_SVH
`define CRCRF_OFS_CRC_HIGH 6'h21
`define CRCRF_OFS_CRC_LOW 6'h22
`define CRCRF_OFS_RSVD_A 6'h23
`define CRCRF_OFS_PULSE_WIDTH 6'h24
`define CRCRF_OFS_RSVD_B 6'h25
`define CRCRF_OFS_RX_GAIN 6'h26
`define CRCRF_OFS_N_DRIVE 6'h27
`define CRCRF_RST_CRC 8'hff
`define CRCRF_RST_RSVD_A 8'h88
`define CRCRF_RST_PULSE_WIDTH 8'h26
`define CRCRF_RST_RSVD_B 8'h87
`define CRCRF_RST_RX_GAIN 8'h48
`define CRCRF_RST_N_DRIVE 8'h88
`define CRCRF_GAIN_LSB 4
`define CRCRF_GAIN_MSB 6
`define CRCRF_RSVD_GAIN_MASK 8'h8f
`define CRCRF_IDLE_LSB 4
`define CRCRF_IDLE_MSB 7
`define CRCRF_MOD_LSB 0
`define CRCRF_MOD_MSB 3
`endif

// File: crcrf_host.sv
// Host model on the register port
`timescale 1ns/10ps
module crcrf_host (
  input wire logic clk,
  input wire logic crc_result_valid,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  // short pulses: callers keep width below 8'h40
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(negedge clk) {reg_wr, reg_wdata} <= {1'b0, ~d};
  endtask : wr
  // waits up to 8 cycles for the done flag before CRC reads
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk) reg_addr <= a;
    for (int i = 0; i < 8 && a inside {6'h21, 6'h22} && crc_result_valid !== 1'b1; i++) @(negedge clk);
    #5 d = reg_rdata;
  endtask : rd
endmodule : crcrf_host

// File: crcrf_pkg.sv
// Types for the CRC/RF configuration register bank
package crcrf_pkg;
  typedef logic [7:0] crcrf_byte_t;
  typedef logic [5:0] crcrf_addr_t;
  typedef logic [3:0] crcrf_cond_t;
  // Receiver gain in dB, decoded from the gain field
  typedef logic [5:0] crcrf_gain_db_t;
endpackage : crcrf_pkg

// File: crcrf_regs.sv
// CRC result and RF driver configuration register bank
`timescale 1ns/10ps
`include "crcrf_cfg.svh"

// Functional notes
// - Offset 0x21 reads the upper CRC byte, read only, all ones after reset.
// - Offset 0x22 reads the lower CRC byte, read only, all ones after reset.
// - The CRC bytes are valid only while the CRC done flag is 1, which the host must check.
// - Reserved offsets 0x23 and 0x25 do nothing and read 0x88 and 0x87.
// - Offset 0x24, reset 0x26, sets the Miller pulse length to setting plus one carrier clocks.
// - Offset 0x26, reset 0x48, holds a writable gain field in bits 6..4, other bits reserved.
// - Gain codes 000/010 give 18 dB, 001/011 give 23, then 33, 38, 43 and 48 dB.
// - Offset 0x27, reset 0x88, holds idle conductance in bits 7..4 and modulation conductance in 3..0.
// - During soft power-down the top bit of each conductance field is forced to 1.
// - Conductance settings are applied only while either antenna driver is on.
// - Each conductance field is binary weighted, each bit twice the one below.
// - The 16-bit CRC is shown as two separate byte registers.
module crcrf_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire crcrf_pkg::crcrf_addr_t reg_addr,
  input wire crcrf_pkg::crcrf_byte_t reg_wdata,
  output crcrf_pkg::crcrf_byte_t reg_rdata,
  input wire logic crc_load,
  input wire logic [15:0] crc_value,
  input wire logic crc_done_flag,
  input wire logic soft_power_down,
  input wire logic antenna_drive_one,
  input wire logic antenna_drive_two,
  output logic crc_result_valid,
  output crcrf_pkg::crcrf_byte_t miller_pulse_length,
  output logic [8:0] miller_pulse_clocks,
  output logic [2:0] rx_gain_select,
  output crcrf_pkg::crcrf_gain_db_t rx_gain_db,
  output crcrf_pkg::crcrf_cond_t n_drive_idle_conductance,
  output crcrf_pkg::crcrf_cond_t n_drive_mod_conductance,
  output logic [4:0] n_drive_idle_weight,
  output logic [4:0] n_drive_mod_weight,
  output logic n_drive_active
);
  import crcrf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  crcrf_byte_t crc_high_byte;
  crcrf_byte_t crc_low_byte;
  crcrf_byte_t pulse_width_reg;
  logic [2:0] gain_field;
  crcrf_byte_t n_drive_reg;
  logic spd_meta, spd_sync;
  logic drv1_meta, drv1_sync, drv2_meta, drv2_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Address hits, one per mapped byte
  wire hit_crc_high = (reg_addr == `CRCRF_OFS_CRC_HIGH);
  wire hit_crc_low = (reg_addr == `CRCRF_OFS_CRC_LOW);
  wire hit_rsvd_a = (reg_addr == `CRCRF_OFS_RSVD_A);
  wire hit_pulse = (reg_addr == `CRCRF_OFS_PULSE_WIDTH);
  wire hit_rsvd_b = (reg_addr == `CRCRF_OFS_RSVD_B);
  wire hit_gain = (reg_addr == `CRCRF_OFS_RX_GAIN);
  wire hit_ndrv = (reg_addr == `CRCRF_OFS_N_DRIVE);
  // Write strobes, only writable bytes decode
  wire wr_pulse = reg_wr && hit_pulse;
  wire wr_gain = reg_wr && hit_gain;
  wire wr_ndrv = reg_wr && hit_ndrv;

  // Pin levels: two flops before use, power-down and driver enables are foreign
  always_ff @(posedge clk) begin
    if (srst) begin
      spd_meta <= 1'b0;
      spd_sync <= 1'b0;
      drv1_meta <= 1'b0;
      drv1_sync <= 1'b0;
      drv2_meta <= 1'b0;
      drv2_sync <= 1'b0;
    end else begin
      spd_meta <= soft_power_down;
      spd_sync <= spd_meta;
      drv1_meta <= antenna_drive_one;
      drv1_sync <= drv1_meta;
      drv2_meta <= antenna_drive_two;
      drv2_sync <= drv2_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      crc_high_byte <= `CRCRF_RST_CRC;
      crc_low_byte <= `CRCRF_RST_CRC;
    end else if (crc_load) begin
      crc_high_byte <= crc_value[15:8];
      crc_low_byte <= crc_value[7:0];
    end
  end

  // Pulse width, gain field and conductance storage, gain reserved bits not stored
  always_ff @(posedge clk) begin
    if (srst) begin
      pulse_width_reg <= `CRCRF_RST_PULSE_WIDTH;
      gain_field <= 3'(`CRCRF_RST_RX_GAIN >> `CRCRF_GAIN_LSB);
      n_drive_reg <= `CRCRF_RST_N_DRIVE;
    end else begin
      if (wr_pulse) pulse_width_reg <= reg_wdata;
      if (wr_gain) gain_field <= reg_wdata[`CRCRF_GAIN_MSB:`CRCRF_GAIN_LSB];
      if (wr_ndrv) n_drive_reg <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  // Reserved bits read their reset pattern, writes to them dropped
  wire crcrf_byte_t gain_read = (`CRCRF_RST_RX_GAIN & `CRCRF_RSVD_GAIN_MASK) | {1'b0, gain_field, 4'h0};
  assign reg_rdata =
    hit_crc_high ? crc_high_byte :
    hit_crc_low ? crc_low_byte :
    hit_rsvd_a ? `CRCRF_RST_RSVD_A :
    hit_pulse ? pulse_width_reg :
    hit_rsvd_b ? `CRCRF_RST_RSVD_B :
    hit_gain ? gain_read :
    hit_ndrv ? n_drive_reg : 8'h00;

  assign crc_result_valid = crc_done_flag;

  // Pulse lasts setting plus one carrier clocks
  assign miller_pulse_length = pulse_width_reg;
  assign miller_pulse_clocks = {1'b0, pulse_width_reg} + 9'h001;

  // Gain decode, codes 0-3 fold onto 18/23 dB
  assign rx_gain_select = gain_field;
  assign rx_gain_db = gain_field[2] ? 6'(6'd33 + {1'b0, gain_field[1:0], 2'b00} + {3'b0, gain_field[1:0]})
                                    : (gain_field[0] ? 6'd23 : 6'd18);

  // Applied only with a driver on
  assign n_drive_active = drv1_sync | drv2_sync;

  wire crcrf_cond_t idle_eff = n_drive_reg[`CRCRF_IDLE_MSB:`CRCRF_IDLE_LSB] | {spd_sync, 3'b000};
  wire crcrf_cond_t mod_eff = n_drive_reg[`CRCRF_MOD_MSB:`CRCRF_MOD_LSB] | {spd_sync, 3'b000};
  assign n_drive_idle_conductance = n_drive_active ? idle_eff : 4'h0;
  assign n_drive_mod_conductance = n_drive_active ? mod_eff : 4'h0;

  // Binary weighted sum, bit i weighs 2**i units
  genvar gi;
  generate
    for (gi = 0; gi < 1; gi++) begin : g_weight
      assign n_drive_idle_weight = {1'b0, n_drive_idle_conductance};
      assign n_drive_mod_weight = {1'b0, n_drive_mod_conductance};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Load reaches high byte
  AST_CRC_HIGH: assert property (@(posedge clk) disable iff (srst)
    crc_load |=> crc_high_byte == $past(crc_value[15:8]))
    else $error("crc high byte not loaded");
  AST_CRC_LOW: assert property (@(posedge clk) disable iff (srst)
    crc_load |=> crc_low_byte == $past(crc_value[7:0]))
    else $error("crc low byte not loaded");
  AST_RD_HIGH: assert property (@(posedge clk) disable iff (srst)
    hit_crc_high |-> reg_rdata == crc_high_byte)
    else $error("crc high byte read wrong");
  AST_RD_LOW: assert property (@(posedge clk) disable iff (srst)
    hit_crc_low |-> reg_rdata == crc_low_byte)
    else $error("crc low byte read wrong");
  AST_CRC_RO: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && !crc_load) |=> $stable(crc_high_byte) && $stable(crc_low_byte))
    else $error("crc written by host");
  AST_CRC_SPLIT: assert property (@(posedge clk) disable iff (srst)
    crc_load |=> {crc_high_byte, crc_low_byte} == $past(crc_value))
    else $error("crc halves split wrong");
  AST_VALID: assert property (@(posedge clk) disable iff (srst)
    crc_result_valid == crc_done_flag)
    else $error("crc validity wrong");

  AST_RSVD: assert property (@(posedge clk) disable iff (srst)
    hit_rsvd_b |-> reg_rdata == 8'h87)
    else $error("reserved slot b wrong");
  AST_RSVD_A: assert property (@(posedge clk) disable iff (srst)
    hit_rsvd_a |-> reg_rdata == 8'h88)
    else $error("reserved slot a wrong");
  AST_UNMAPPED: assert property (@(posedge clk) disable iff (srst)
    (reg_addr < 6'h21 || reg_addr > 6'h27) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_PULSE: assert property (@(posedge clk) disable iff (srst)
    wr_pulse |=> miller_pulse_clocks == {1'b0, $past(reg_wdata)} + 9'h001)
    else $error("pulse length wrong");
  AST_PULSE_HOLD: assert property (@(posedge clk) disable iff (srst)
    !wr_pulse |=> $stable(pulse_width_reg))
    else $error("pulse width moved");
  AST_PULSE_RD: assert property (@(posedge clk) disable iff (srst)
    hit_pulse |-> reg_rdata == miller_pulse_length)
    else $error("pulse width read wrong");

  AST_GAIN_RSVD: assert property (@(posedge clk) disable iff (srst)
    hit_gain |-> (reg_rdata & 8'h8f) == 8'h08)
    else $error("gain reserved bits moved");
  AST_GAIN_WR: assert property (@(posedge clk) disable iff (srst)
    wr_gain |=> rx_gain_select == $past(reg_wdata[`CRCRF_GAIN_MSB:`CRCRF_GAIN_LSB]))
    else $error("gain field not written");
  AST_GAIN_HOLD: assert property (@(posedge clk) disable iff (srst)
    !wr_gain |=> $stable(rx_gain_select))
    else $error("gain field moved");
  AST_GAIN_RD: assert property (@(posedge clk) disable iff (srst)
    hit_gain |-> reg_rdata[6:4] == rx_gain_select)
    else $error("gain field read wrong");
  AST_GAIN_C0: assert property (@(posedge clk) disable iff (srst)
    rx_gain_select == 3'h0 |-> rx_gain_db == 6'd18)
    else $error("gain code 0 wrong");
  AST_GAIN_C1: assert property (@(posedge clk) disable iff (srst)
    rx_gain_select == 3'h1 |-> rx_gain_db == 6'd23)
    else $error("gain code 1 wrong");
  AST_GAIN_C2: assert property (@(posedge clk) disable iff (srst)
    rx_gain_select == 3'h2 |-> rx_gain_db == 6'd18)
    else $error("gain code 2 wrong");
  AST_GAIN_C3: assert property (@(posedge clk) disable iff (srst)
    rx_gain_select == 3'h3 |-> rx_gain_db == 6'd23)
    else $error("gain code 3 wrong");
  AST_GAIN_C4: assert property (@(posedge clk) disable iff (srst)
    rx_gain_select == 3'h4 |-> rx_gain_db == 6'd33)
    else $error("gain code 4 wrong");
  AST_GAIN_C5: assert property (@(posedge clk) disable iff (srst)
    rx_gain_select == 3'h5 |-> rx_gain_db == 6'd38)
    else $error("gain code 5 wrong");
  AST_GAIN_C6: assert property (@(posedge clk) disable iff (srst)
    rx_gain_select == 3'h6 |-> rx_gain_db == 6'd43)
    else $error("gain code 6 wrong");
  AST_GAIN_MAX: assert property (@(posedge clk) disable iff (srst)
    rx_gain_select == 3'h7 |-> rx_gain_db == 6'd48)
    else $error("gain decode wrong");

  AST_NDRV_WR: assert property (@(posedge clk) disable iff (srst)
    wr_ndrv |=> n_drive_reg == $past(reg_wdata))
    else $error("conductance not written");
  AST_NDRV_HOLD: assert property (@(posedge clk) disable iff (srst)
    !wr_ndrv |=> $stable(n_drive_reg))
    else $error("conductance moved");
  AST_NDRV_RD: assert property (@(posedge clk) disable iff (srst)
    hit_ndrv |-> reg_rdata == n_drive_reg)
    else $error("conductance read wrong");
  AST_IDLE_APPLY: assert property (@(posedge clk) disable iff (srst)
    (n_drive_active && !spd_sync) |-> n_drive_idle_conductance == n_drive_reg[7:4])
    else $error("idle conductance wrong");
  AST_MOD_APPLY: assert property (@(posedge clk) disable iff (srst)
    (n_drive_active && !spd_sync) |-> n_drive_mod_conductance == n_drive_reg[3:0])
    else $error("modulation conductance wrong");

  // Forced top bit after sync delay
  AST_SPD: assert property (@(posedge clk) disable iff (srst)
    (soft_power_down && n_drive_active) [*3] |-> n_drive_idle_conductance[3] && n_drive_mod_conductance[3])
    else $error("power-down force missing");
  AST_SPD_LOW: assert property (@(posedge clk) disable iff (srst)
    n_drive_active |-> n_drive_idle_conductance[2:0] == n_drive_reg[6:4] && n_drive_mod_conductance[2:0] == n_drive_reg[2:0])
    else $error("conductance low bits wrong");
  AST_DRV_OFF: assert property (@(posedge clk) disable iff (srst)
    !n_drive_active |-> n_drive_idle_conductance == 4'h0 && n_drive_mod_conductance == 4'h0)
    else $error("conductance applied while off");
  AST_DRV_SYNC: assert property (@(posedge clk) disable iff (srst)
    $rose(n_drive_active) |-> $past(antenna_drive_one || antenna_drive_two, 2))
    else $error("driver enable without pin");

  AST_WEIGHT_IDLE: assert property (@(posedge clk) disable iff (srst)
    n_drive_idle_weight == 5'(8 * n_drive_idle_conductance[3] + 4 * n_drive_idle_conductance[2]
      + 2 * n_drive_idle_conductance[1] + n_drive_idle_conductance[0]))
    else $error("idle weight wrong");
  AST_WEIGHT_MOD: assert property (@(posedge clk) disable iff (srst)
    n_drive_mod_weight == 5'(8 * n_drive_mod_conductance[3] + 4 * n_drive_mod_conductance[2]
      + 2 * n_drive_mod_conductance[1] + n_drive_mod_conductance[0]))
    else $error("modulation weight wrong");
endmodule : crcrf_regs

// File: tb.sv
// Self-checking bench for the CRC/RF register bank
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ld = 1'b0;
  logic done = 1'b0;
  logic pd = 1'b0;
  logic a1 = 1'b0;
  logic a2 = 1'b0;
  logic [15:0] crc = 16'h0000;
  logic wr, valid, act;
  logic [5:0] addr, gdb;
  logic [7:0] wd, rdata, mpl, rd;
  logic [8:0] mclk;
  logic [2:0] gsel;
  logic [3:0] ic, mc;
  logic [4:0] iw, mw;
  int bad_count = 0;
  int total_checks = 0;
  // Address, write data, read back
  logic [21:0] rows [9] = '{{6'h24, 8'h3f, 8'h3f}, {6'h26, 8'hff, 8'h78}, {6'h26, 8'h00, 8'h08},
    {6'h27, 8'h3c, 8'h3c}, {6'h21, 8'h00, 8'hff}, {6'h22, 8'h00, 8'hff}, {6'h23, 8'h00, 8'h88},
    {6'h25, 8'h00, 8'h87}, {6'h3f, 8'h55, 8'h00}};
  logic [13:0] rrows [7] = '{{6'h24, 8'h26}, {6'h26, 8'h48}, {6'h27, 8'h88}, {6'h21, 8'hff},
    {6'h22, 8'hff}, {6'h23, 8'h88}, {6'h25, 8'h87}};
  logic [5:0] db [8] = '{6'd18, 6'd23, 6'd18, 6'd23, 6'd33, 6'd38, 6'd43, 6'd48};
  always #10 clk = ~clk;
  crcrf_regs u_dut (.clk(clk), .srst(srst), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdata), .crc_load(ld), .crc_value(crc), .crc_done_flag(done), .soft_power_down(pd),
    .antenna_drive_one(a1), .antenna_drive_two(a2), .crc_result_valid(valid), .miller_pulse_length(mpl),
    .miller_pulse_clocks(mclk), .rx_gain_select(gsel), .rx_gain_db(gdb), .n_drive_idle_conductance(ic),
    .n_drive_mod_conductance(mc), .n_drive_idle_weight(iw), .n_drive_mod_weight(mw), .n_drive_active(act));
  crcrf_host u_host (.clk(clk), .crc_result_valid(valid), .reg_rdata(rdata), .reg_wr(wr),
    .reg_addr(addr), .reg_wdata(wd));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  // Driver pins pass two sync flops, so allow settling
  task automatic pins(input logic [2:0] p);
    @(negedge clk) {pd, a1, a2} <= p;
    repeat (4) @(negedge clk);
  endtask : pins
  initial begin
    repeat (20) @(negedge clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      u_host.wr(rows[i][21:16], rows[i][15:8]);
      u_host.rd(rows[i][21:16], rd);
      chk(rd, rows[i][7:0]);
    end
    chk({mpl, mclk}, {8'h3f, 9'h040});
    for (int g = 0; g < 8; g++) begin
      u_host.wr(6'h26, {1'b1, g[2:0], 4'hf});
      chk({gsel, gdb}, {g[2:0], db[g]});
    end
    u_host.wr(6'h27, 8'h6a);
    pins(3'b000);
    chk({ic, mc, act}, 9'h000);
    pins(3'b010);
    chk({ic, mc, iw, mw, act}, {8'h6a, 5'd6, 5'd10, 1'b1});
    pins(3'b101);
    chk({ic, mc, iw, mw, act}, {8'hea, 5'd14, 5'd10, 1'b1});
    pins(3'b000);
    chk(valid, 1'b0);
    // CRC bytes load together and stay write protected
    @(negedge clk) {ld, crc, done} <= {1'b1, 16'h1234, 1'b1};
    @(negedge clk) ld <= 1'b0;
    u_host.wr(6'h22, 8'h00);
    u_host.rd(6'h21, rd);
    chk({valid, rd}, 9'h112);
    u_host.rd(6'h22, rd);
    chk(rd, 8'h34);
    // Mid-run reset restores every byte
    @(negedge clk) srst <= 1'b1;
    @(negedge clk) srst <= 1'b0;
    foreach (rrows[i]) begin
      u_host.rd(rrows[i][13:8], rd);
      chk(rd, rrows[i][7:0]);
    end
    results();
  end
  // Watchdog well beyond the few microseconds of tests
  initial begin
    #100000;
    bad_count++;
    results();
  end
endmodule : tb
